// ---- swirq_defines.svh ----
`ifndef SWIRQ_DEFINES_SVH
`define SWIRQ_DEFINES_SVH

// Serial frame: 32 data bits sent first (most significant first), then the parity bit.
`define SWIRQ_DATA_BITS        32
`define SWIRQ_FRAME_BITS       33
`define SWIRQ_FRAME_CNT        6'h21
`define SWIRQ_FRAME_CNT_W      6

// Received command fields, as positions inside the 33-bit receive shift register.
`define SWIRQ_CMD_RW_BIT       32
`define SWIRQ_CMD_ADDR_HI      31
`define SWIRQ_CMD_ADDR_LO      26
`define SWIRQ_CMD_READ         1'h0
`define SWIRQ_EVT_STAT_ADDR    6'h21

// Event status bit positions.
`define SWIRQ_ESR_W            4
`define SWIRQ_ESR_SWITCH       0
`define SWIRQ_ESR_WARN         1
`define SWIRQ_ESR_SHUTDOWN     2
`define SWIRQ_ESR_PARITY       3
`define SWIRQ_ESR_RESET        4'h0

// Serial status word field positions.
`define SWIRQ_SW_PARITY        31
`define SWIRQ_SW_TEMP          30
`define SWIRQ_SW_SWITCH        29
`define SWIRQ_SW_STATE_MAX     24

// Wetting current codes.
`define SWIRQ_CUR_W            3
`define SWIRQ_CUR_OFF          3'h0
`define SWIRQ_CUR_2MA          3'h2
`define SWIRQ_CUR_10MA         3'h4
`define SWIRQ_CUR_15MA         3'h5

// Debounce selection; the reset value interrupts on every crossing.
`define SWIRQ_DEB_RESET        2'h0
`define SWIRQ_DEB_CNT_W        3
`define SWIRQ_DEB_CNT_ONE      3'h1
`define SWIRQ_DEB_CNT_ZERO     3'h0

`endif

// ---- swirq_pkg.sv ----
`include "swirq_defines.svh"
`default_nettype none

package swirq_pkg;
   typedef logic [`SWIRQ_CUR_W-1:0]       swirq_wcur_t;   // Wetting current code.
   typedef logic [`SWIRQ_DEB_CNT_W-1:0]   swirq_cnt_t;    // Debounce counter.
   typedef logic [`SWIRQ_FRAME_BITS-1:0]  swirq_frame_t;  // One serial frame.
   typedef logic [`SWIRQ_FRAME_CNT_W-1:0] swirq_bitcnt_t; // Serial bit counter.
endpackage : swirq_pkg

`default_nettype wire

// ---- swirq.sv ----
// Summary of operation
// - Event pin floats until an event, then low.
// - Two enable sets choose per-input edge interrupts.
// - Rising mode: now above, before below.
// - Falling mode: now below, before above.
// - Both-edges mode: any change interrupts.
// - Change interrupts disabled after reset.
// - Debounce: any crossing, or stable 2/3/4.
// - Select 11 needs four stable detection cycles.
// - Reference stored after first detection cycle.
// - Stopping monitoring clears debounce; reset selects any.
// - Warning entry: event, flag, temp, level set.
// - Warning reduces 10/15 mA to 2 mA.
// - Keep bit: interrupt, but currents unreduced.
// - Status read releases pin, clears status.
// - Persisting warning: level stays, no new interrupts.
// - Warning exit: event, flag, level clear, restore.
// - Shutdown entry: currents off, event, levels set.
// - Shutdown exit: event, flag, level cleared.
// - After shutdown, restart polling, new references.
// - Outgoing word carries odd parity.
// - Even received word: discard, event, parity flag.
`include "swirq_defines.svh"
`timescale 1ns/100ps
`default_nettype none

module swirq_top
#(
   parameter int N_INPUTS = 24
)
(
   input  wire logic                             CLOCK,
   input  wire logic                             RST,
   input  wire logic                             SCLK,
   input  wire logic                             CS_N,
   input  wire logic                             SI,
   output logic                                  SO,
   input  wire logic                             EVENT_N_I,
   output logic                                  EVENT_N_O,
   output logic                                  EVENT_N_OE_N,
   input  wire logic [N_INPUTS-1:0]              CHANGE_IRQ_ENABLE_A,
   input  wire logic [N_INPUTS-1:0]              CHANGE_IRQ_ENABLE_B,
   input  wire logic [1:0]                       DEBOUNCE_SELECT,
   input  wire logic                             START_MONITOR,
   input  wire logic                             SAMPLE_STROBE,
   input  wire logic [N_INPUTS-1:0]              SAMPLE_ABOVE,
   input  wire logic [N_INPUTS-1:0]              CURRENT_SINK_SEL,
   input  wire logic [N_INPUTS*`SWIRQ_CUR_W-1:0] WETTING_SETTING,
   input  wire logic                             TEMP_WARN_IN,
   input  wire logic                             TEMP_SHUTDOWN_IN,
   input  wire logic                             WARN_KEEP_SOURCE_CURRENT,
   input  wire logic                             WARN_KEEP_SINK_CURRENT,
   output logic [N_INPUTS*`SWIRQ_CUR_W-1:0]      WETTING_APPLIED,
   output logic [N_INPUTS-1:0]                   REFERENCE_STATE,
   output logic [`SWIRQ_ESR_W-1:0]               EVENT_STATUS,
   output logic                                  THERMAL_WARNING_LEVEL,
   output logic                                  THERMAL_SHUTDOWN_LEVEL,
   output logic                                  POLL_RESTART
);

   // The serial status word has room for at most 24 reference states.
   if (N_INPUTS < 1 || N_INPUTS > `SWIRQ_SW_STATE_MAX)
   begin : g_bad_inputs
      $error("N_INPUTS must lie between 1 and 24.");
   end

   // Odd parity bit for a 32-bit word: data plus parity holds an odd count of ones.
   function automatic logic odd_parity(input logic [`SWIRQ_DATA_BITS-1:0] word);
      odd_parity = ~(^word);
   endfunction : odd_parity

   // Number of consecutive differing cycles needed before a change is accepted.
   function automatic swirq_pkg::swirq_cnt_t needed_cycles(input logic [1:0] sel);
      needed_cycles = {1'b0, sel} + `SWIRQ_DEB_CNT_ONE;
   endfunction : needed_cycles

   // Current actually applied to one input under thermal conditions.
   function automatic swirq_pkg::swirq_wcur_t applied_current(
      input swirq_pkg::swirq_wcur_t code,
      input logic                   shut,
      input logic                   warn,
      input logic                   keep);
      if (shut)
      begin
         applied_current = `SWIRQ_CUR_OFF;
      end
      else if (warn && !keep && (code == `SWIRQ_CUR_10MA || code == `SWIRQ_CUR_15MA))
      begin
         applied_current = `SWIRQ_CUR_2MA;
      end
      else
      begin
         applied_current = code;
      end
   endfunction : applied_current

   // Link-side state, clocked by SCLK.
   swirq_pkg::swirq_bitcnt_t tx_cnt_reg;      // Rising edges seen in this frame.
   swirq_pkg::swirq_frame_t  tx_shift_reg;    // Outgoing bits still to send.
   logic                     so_reg;          // Serial output flop.
   swirq_pkg::swirq_bitcnt_t rx_cnt_reg;      // Falling edges seen in this frame.
   swirq_pkg::swirq_frame_t  rx_shift_reg;    // Received frame, parity in bit 0.

   // Core-side synchronisers.
   logic cs_s1_reg;                           // First stage, read by the second only.
   logic cs_s2_reg;                           // Synchronised chip select.
   logic cs_s3_reg;                           // Delayed copy for edge detection.
   logic tw_s1_reg;                           // First stage of the warning input.
   logic tw_s2_reg;                           // Synchronised warning input.
   logic tw_s3_reg;                           // Delayed copy for edge detection.
   logic sd_s1_reg;                           // First stage of the shutdown input.
   logic sd_s2_reg;                           // Synchronised shutdown input.
   logic sd_s3_reg;                           // Delayed copy for edge detection.

   // Captured configuration with defined reset values.
   logic [N_INPUTS-1:0] en_rise_reg;          // Rising-edge interrupt enables.
   logic [N_INPUTS-1:0] en_fall_reg;          // Falling-edge interrupt enables.
   logic [1:0]          deb_sel_reg;          // Debounce selection.
   logic                keep_src_reg;        // Keep source currents during warning.
   logic                keep_snk_reg;        // Keep sink currents during warning.

   // Core state.
   logic [N_INPUTS-1:0]            ref_reg;   // Stored reference states.
   swirq_pkg::swirq_cnt_t          cnt_reg [N_INPUTS]; // Debounce counters.
   logic                           first_reg; // Next detection cycle is a first one.
   logic [`SWIRQ_ESR_W-1:0]        esr_reg;   // Event status flags.
   logic [`SWIRQ_ESR_W-1:0]        esr_next;  // Next value of the flags.
   logic                           oe_n_reg;  // Event pin enable, low drives.
   logic                           drv_reg;   // Level driven when enabled.
   logic                           warn_lvl_reg;
   logic                           shut_lvl_reg;
   logic                           restart_reg;
   logic [N_INPUTS*`SWIRQ_CUR_W-1:0] wet_reg; // Applied currents.
   swirq_pkg::swirq_frame_t        tx_word_reg; // Reply frame held for the link.

   // Combinational decode.
   logic                frame_end;            // Chip select has just risen.
   logic                frame_full;           // Exactly one whole frame arrived.
   logic                parity_good;          // Received frame has odd parity.
   logic                read_clear;           // Valid read of the event status.
   logic                parity_evt;           // Frame discarded for bad parity.
   logic                tw_rise;
   logic                tw_fall;
   logic                sd_rise;
   logic                sd_fall;
   logic                detect;               // A detection cycle to evaluate.
   logic [N_INPUTS-1:0] settle;               // Input change accepted this cycle.
   logic [N_INPUTS-1:0] fire;                 // Accepted change that interrupts.
   logic                switch_evt;           // Switch change event this cycle.
   logic [`SWIRQ_DATA_BITS-1:0] status_word;  // Reply word before parity.

   // Transmit side: loads the held reply at the first rising edge, then shifts.
   always_ff @(posedge SCLK or posedge CS_N)
   begin
      if (CS_N)
      begin
         tx_cnt_reg   <= '0;
         tx_shift_reg <= '0;
         so_reg       <= 1'b0;
      end
      else if (tx_cnt_reg == '0)
      begin
         so_reg       <= tx_word_reg[`SWIRQ_FRAME_BITS-1];
         tx_shift_reg <= {tx_word_reg[`SWIRQ_FRAME_BITS-2:0], 1'b0};
         tx_cnt_reg   <= swirq_pkg::swirq_bitcnt_t'(1);
      end
      else
      begin
         so_reg       <= tx_shift_reg[`SWIRQ_FRAME_BITS-1];
         tx_shift_reg <= {tx_shift_reg[`SWIRQ_FRAME_BITS-2:0], 1'b0};
         if (tx_cnt_reg != `SWIRQ_FRAME_CNT + swirq_pkg::swirq_bitcnt_t'(1))
         begin
            tx_cnt_reg <= tx_cnt_reg + swirq_pkg::swirq_bitcnt_t'(1);
         end
      end
   end

   // Receive side: samples SI on falling edges; it survives chip select
   // rising so that the core can read it once the clock has stopped.
   always_ff @(negedge SCLK)
   begin
      rx_shift_reg <= {rx_shift_reg[`SWIRQ_FRAME_BITS-2:0], SI};
      if (tx_cnt_reg == swirq_pkg::swirq_bitcnt_t'(1))
      begin
         rx_cnt_reg <= swirq_pkg::swirq_bitcnt_t'(1);
      end
      else if (rx_cnt_reg != `SWIRQ_FRAME_CNT + swirq_pkg::swirq_bitcnt_t'(1))
      begin
         rx_cnt_reg <= rx_cnt_reg + swirq_pkg::swirq_bitcnt_t'(1);
      end
   end

   // Synchronisers for chip select and the two thermal comparators.
   always_ff @(posedge CLOCK)
   begin
      if (RST)
      begin
         {cs_s1_reg, cs_s2_reg, cs_s3_reg} <= 3'h7;
         {tw_s1_reg, tw_s2_reg, tw_s3_reg} <= 3'h0;
         {sd_s1_reg, sd_s2_reg, sd_s3_reg} <= 3'h0;
      end
      else
      begin
         {cs_s1_reg, cs_s2_reg, cs_s3_reg} <= {CS_N, cs_s1_reg, cs_s2_reg};
         {tw_s1_reg, tw_s2_reg, tw_s3_reg} <= {TEMP_WARN_IN, tw_s1_reg, tw_s2_reg};
         {sd_s1_reg, sd_s2_reg, sd_s3_reg} <= {TEMP_SHUTDOWN_IN, sd_s1_reg, sd_s2_reg};
      end
   end

   // Frame decode; the receive registers are still because SCLK has stopped.
   always_comb
   begin
      frame_end   = cs_s2_reg & ~cs_s3_reg;
      frame_full  = (rx_cnt_reg == `SWIRQ_FRAME_CNT);
      parity_good = ^rx_shift_reg;
      read_clear  = frame_end && frame_full && parity_good
                    && rx_shift_reg[`SWIRQ_CMD_RW_BIT] == `SWIRQ_CMD_READ
                    && rx_shift_reg[`SWIRQ_CMD_ADDR_HI:`SWIRQ_CMD_ADDR_LO]
                       == `SWIRQ_EVT_STAT_ADDR;
      parity_evt  = frame_end && frame_full && !parity_good;
   end

   // Thermal edges seen on the synchronised comparator outputs.
   always_comb
   begin
      tw_rise = tw_s2_reg & ~tw_s3_reg;
      tw_fall = ~tw_s2_reg & tw_s3_reg;
      sd_rise = sd_s2_reg & ~sd_s3_reg;
      sd_fall = ~sd_s2_reg & sd_s3_reg;
   end

   // Configuration capture; everything comes out of reset disabled.
   always_ff @(posedge CLOCK)
   begin
      if (RST)
      begin
         en_rise_reg  <= '0;
         en_fall_reg  <= '0;
         deb_sel_reg  <= `SWIRQ_DEB_RESET;
         keep_src_reg <= 1'b0;
         keep_snk_reg <= 1'b0;
      end
      else
      begin
         en_rise_reg  <= CHANGE_IRQ_ENABLE_A;
         en_fall_reg  <= CHANGE_IRQ_ENABLE_B;
         deb_sel_reg  <= DEBOUNCE_SELECT;
         keep_src_reg <= WARN_KEEP_SOURCE_CURRENT;
         keep_snk_reg <= WARN_KEEP_SINK_CURRENT;
      end
   end

   // Thermal levels; the warning level stays up throughout shutdown.
   always_ff @(posedge CLOCK)
   begin
      if (RST)
      begin
         warn_lvl_reg <= 1'b0;
         shut_lvl_reg <= 1'b0;
      end
      else
      begin
         warn_lvl_reg <= tw_s2_reg | sd_s2_reg;
         shut_lvl_reg <= sd_s2_reg;
      end
   end

   // Change detection for one detection cycle; no sampling during shutdown.
   always_comb
   begin
      detect = SAMPLE_STROBE && START_MONITOR && !shut_lvl_reg;
      for (int i = 0; i < N_INPUTS; i++)
      begin
         // The change must have persisted for the selected number of cycles.
         settle[i] = (SAMPLE_ABOVE[i] != ref_reg[i])
                     && (cnt_reg[i] + `SWIRQ_DEB_CNT_ONE >= needed_cycles(deb_sel_reg));
         fire[i]   = settle[i] && ((SAMPLE_ABOVE[i] && en_rise_reg[i])
                     || (!SAMPLE_ABOVE[i] && en_fall_reg[i]));
      end
      switch_evt = detect && (first_reg || (|fire));
   end

   // Reference states and debounce counters.
   always_ff @(posedge CLOCK)
   begin
      if (RST)
      begin
         ref_reg <= '0;
         for (int i = 0; i < N_INPUTS; i++)
         begin
            cnt_reg[i] <= `SWIRQ_DEB_CNT_ZERO;
         end
      end
      else if (!START_MONITOR)
      begin
         // Stopping monitoring forgets any partial debounce.
         for (int i = 0; i < N_INPUTS; i++)
         begin
            cnt_reg[i] <= `SWIRQ_DEB_CNT_ZERO;
         end
      end
      else if (detect)
      begin
         for (int i = 0; i < N_INPUTS; i++)
         begin
            if (first_reg)
            begin
               // First cycle takes the samples as references unfiltered.
               ref_reg[i] <= SAMPLE_ABOVE[i];
               cnt_reg[i] <= `SWIRQ_DEB_CNT_ZERO;
            end
            else if (settle[i])
            begin
               ref_reg[i] <= SAMPLE_ABOVE[i];
               cnt_reg[i] <= `SWIRQ_DEB_CNT_ZERO;
            end
            else if (SAMPLE_ABOVE[i] != ref_reg[i])
            begin
               cnt_reg[i] <= cnt_reg[i] + `SWIRQ_DEB_CNT_ONE;
            end
            else
            begin
               // A bounce back to the reference restarts the count.
               cnt_reg[i] <= `SWIRQ_DEB_CNT_ZERO;
            end
         end
      end
   end

   // First-cycle marker: rearmed by stopping monitoring or leaving shutdown.
   always_ff @(posedge CLOCK)
   begin
      if (RST)
      begin
         first_reg <= 1'b1;
      end
      else if (!START_MONITOR || sd_fall)
      begin
         first_reg <= 1'b1;
      end
      else if (detect)
      begin
         first_reg <= 1'b0;
      end
   end

   // Polling restart pulse after shutdown recovery.
   always_ff @(posedge CLOCK)
   begin
      if (RST)
      begin
         restart_reg <= 1'b0;
      end
      else
      begin
         restart_reg <= sd_fall;
      end
   end

   // Event status flags; a new event in the clearing cycle is kept.
   always_comb
   begin
      esr_next = esr_reg & {`SWIRQ_ESR_W{~read_clear}};
      esr_next[`SWIRQ_ESR_SWITCH]   = esr_next[`SWIRQ_ESR_SWITCH] | switch_evt;
      esr_next[`SWIRQ_ESR_WARN]     = esr_next[`SWIRQ_ESR_WARN] | tw_rise | tw_fall;
      esr_next[`SWIRQ_ESR_SHUTDOWN] = esr_next[`SWIRQ_ESR_SHUTDOWN] | sd_rise | sd_fall;
      esr_next[`SWIRQ_ESR_PARITY]   = esr_next[`SWIRQ_ESR_PARITY] | parity_evt;
   end

   // Event status register.
   always_ff @(posedge CLOCK)
   begin
      if (RST)
      begin
         esr_reg <= `SWIRQ_ESR_RESET;
      end
      else
      begin
         esr_reg <= esr_next;
      end
   end

   // Event pin: floats until an event, then pulls low until a status read.
   always_ff @(posedge CLOCK)
   begin
      if (RST)
      begin
         oe_n_reg <= 1'b1;
         drv_reg  <= 1'b0;
      end
      else if (switch_evt || tw_rise || tw_fall || sd_rise || sd_fall || parity_evt)
      begin
         oe_n_reg <= 1'b0;
      end
      else if (read_clear)
      begin
         oe_n_reg <= 1'b1;
      end
   end

   // Applied wetting currents under warning and shutdown.
   always_ff @(posedge CLOCK)
   begin
      if (RST)
      begin
         wet_reg <= '0;
      end
      else
      begin
         for (int i = 0; i < N_INPUTS; i++)
         begin
            wet_reg[i*`SWIRQ_CUR_W +: `SWIRQ_CUR_W] <= applied_current(
               WETTING_SETTING[i*`SWIRQ_CUR_W +: `SWIRQ_CUR_W],
               shut_lvl_reg,
               warn_lvl_reg,
               CURRENT_SINK_SEL[i] ? keep_snk_reg : keep_src_reg);
         end
      end
   end

   // Reply word: status flags on top, reference states at the bottom.
   always_comb
   begin
      status_word = '0;
      status_word[N_INPUTS-1:0]        = ref_reg;
      status_word[`SWIRQ_SW_SWITCH]    = esr_reg[`SWIRQ_ESR_SWITCH];
      status_word[`SWIRQ_SW_TEMP]      = warn_lvl_reg | esr_reg[`SWIRQ_ESR_WARN]
                                         | esr_reg[`SWIRQ_ESR_SHUTDOWN];
      status_word[`SWIRQ_SW_PARITY]    = esr_reg[`SWIRQ_ESR_PARITY];
   end

   // The reply is frozen while chip select is low so the link sees it steady.
   always_ff @(posedge CLOCK)
   begin
      if (RST)
      begin
         tx_word_reg <= {{`SWIRQ_DATA_BITS{1'b0}}, 1'b1};
      end
      else if (cs_s2_reg)
      begin
         tx_word_reg <= {status_word, odd_parity(status_word)};
      end
   end

   assign SO                     = so_reg;
   assign EVENT_N_O              = drv_reg;
   assign EVENT_N_OE_N           = oe_n_reg;
   assign WETTING_APPLIED        = wet_reg;
   assign REFERENCE_STATE        = ref_reg;
   assign EVENT_STATUS           = esr_reg;
   assign THERMAL_WARNING_LEVEL  = warn_lvl_reg;
   assign THERMAL_SHUTDOWN_LEVEL = shut_lvl_reg;
   assign POLL_RESTART           = restart_reg;

endmodule : swirq_top

`default_nettype wire

// ---- swirq_assertions.sv ----
`include "swirq_defines.svh"
`timescale 1ns/100ps
`default_nettype none

// Watches the event pin, thermal levels and detection results at the top ports.
module swirq_assertions
#(
   parameter int N_INPUTS = 24
)
(
   input wire logic                             CLOCK,
   input wire logic                             RST,
   input wire logic                             EVENT_N_O,
   input wire logic                             EVENT_N_OE_N,
   input wire logic                             SAMPLE_STROBE,
   input wire logic                             START_MONITOR,
   input wire logic [N_INPUTS-1:0]              REFERENCE_STATE,
   input wire logic [N_INPUTS*`SWIRQ_CUR_W-1:0] WETTING_APPLIED,
   input wire logic [`SWIRQ_ESR_W-1:0]          EVENT_STATUS,
   input wire logic                             THERMAL_WARNING_LEVEL,
   input wire logic                             THERMAL_SHUTDOWN_LEVEL,
   input wire logic                             POLL_RESTART
);
   default clocking cb @(posedge CLOCK);
   endclocking
   default disable iff (RST);

   AST_PIN_DRIVE: assert property (EVENT_N_O == 1'h0)
      else $error("event pin drive level is not low");
   AST_PIN_PENDING: assert property (EVENT_STATUS != 4'h0 |-> !EVENT_N_OE_N)
      else $error("event pending but pin released");
   AST_RELEASE_CLEAR: assert property ($rose(EVENT_N_OE_N) |-> EVENT_STATUS == 4'h0)
      else $error("pin released with status still set");
   AST_IDLE_REFUSED: assert property (SAMPLE_STROBE && !START_MONITOR |=> $stable(REFERENCE_STATE))
      else $error("reference moved while monitoring stopped");
   AST_SHUT_REFUSED: assert property (SAMPLE_STROBE && THERMAL_SHUTDOWN_LEVEL |=> $stable(REFERENCE_STATE))
      else $error("reference moved during shutdown");
   AST_WARN_HELD: assert property (THERMAL_SHUTDOWN_LEVEL |-> THERMAL_WARNING_LEVEL)
      else $error("warning level low during shutdown");
   AST_WARN_ENTRY: assert property ($rose(THERMAL_WARNING_LEVEL) |=> EVENT_STATUS[1] && !EVENT_N_OE_N)
      else $error("warning entry not flagged");
   AST_WARN_EXIT: assert property ($fell(THERMAL_WARNING_LEVEL) |=> EVENT_STATUS[1])
      else $error("warning exit not flagged");
   AST_SHUT_EDGE: assert property ($changed(THERMAL_SHUTDOWN_LEVEL) |=> EVENT_STATUS[2])
      else $error("shutdown change not flagged");
   AST_SHUT_OFF: assert property (THERMAL_SHUTDOWN_LEVEL |=> WETTING_APPLIED == '0)
      else $error("currents applied during shutdown");
   AST_RESTART: assert property ($fell(THERMAL_SHUTDOWN_LEVEL) |-> ##[0:2] POLL_RESTART)
      else $error("no polling restart after shutdown");

   // Main scenarios: shutdown, status read release and a strobe while monitoring is on.
   CV_SHUT: cover property ($rose(THERMAL_SHUTDOWN_LEVEL));
   CV_RELEASE: cover property ($rose(EVENT_N_OE_N));
   CV_STROBE: cover property (SAMPLE_STROBE && START_MONITOR);
endmodule : swirq_assertions

bind swirq_top swirq_assertions #(.N_INPUTS(N_INPUTS)) u_chk (
   .CLOCK(CLOCK), .RST(RST), .EVENT_N_O(EVENT_N_O), .EVENT_N_OE_N(EVENT_N_OE_N),
   .SAMPLE_STROBE(SAMPLE_STROBE), .START_MONITOR(START_MONITOR),
   .REFERENCE_STATE(REFERENCE_STATE), .WETTING_APPLIED(WETTING_APPLIED),
   .EVENT_STATUS(EVENT_STATUS), .THERMAL_WARNING_LEVEL(THERMAL_WARNING_LEVEL),
   .THERMAL_SHUTDOWN_LEVEL(THERMAL_SHUTDOWN_LEVEL), .POLL_RESTART(POLL_RESTART));

`default_nettype wire

// ---- swirq_host.sv ----
`timescale 1ns/100ps
`default_nettype none

// Host side of the serial link; the link clock only runs inside frames.
module swirq_host (
   output logic      SCLK,
   output logic      CS_N,
   output logic      SI,
   input  wire logic SO,
   output logic      host_regulator_hold
);
   initial
   begin
      SCLK = 1'b0;
      CS_N = 1'b0;
      SI = 1'b0;
      host_regulator_hold = 1'b0;
      // A clean rising chip select clears the transmit logic, which has no reset.
      #2 CS_N = 1'b1;
   end

   // Sends one 33-bit frame, most significant first, and collects the reply.
   task automatic xfer(input logic [31:0] w, input logic bad, output logic [32:0] rx);
      logic [32:0] f;
      f = {w, (~^w) ^ bad};
      if (w[31] == 1'b0)
         host_regulator_hold = 1'b1;
      #7 CS_N = 1'b0;
      #40;
      for (int i = 32; i >= 0; i--)
      begin
         SI = f[i];
         SCLK = 1'b1;
         #40 rx[i] = SO;
         SCLK = 1'b0;
         #40;
      end
      CS_N = 1'b1;
      // A released data line does not keep its last level.
      SI = ~SI;
      #80;
   endtask : xfer
endmodule : swirq_host

`default_nettype wire

// ---- swirq_tb.sv ----
`timescale 1ns/100ps
`default_nettype none

module tb;
   logic        clock = 1'b0, rst = 1'b1, mon = 1'b0, strb = 1'b0, warn = 1'b0, shut = 1'b0;
   logic        keep_so = 1'b1, keep_si = 1'b0, ev_i, ev_o, oe_n, sclk, cs_n, si, so;
   logic        wlev, slev, prst;
   logic [1:0]  deb = 2'h0;
   logic [3:0]  en_a = 4'h0, en_b = 4'h0, above = 4'h0, sink = 4'h2, ref_st, evs;
   logic [11:0] wset = 12'h4e5, wapp;
   logic [32:0] rx;
   logic [3:0]  pat [6] = '{4'h4, 4'h5, 4'h7, 4'h5, 4'h1, 4'h9};
   logic [5:0]  flg = 6'h1a;
   int          errors = 0, cmp_count = 0;

   always #5 clock = ~clock;
   // The pin has a pull-up, so it reads high whenever released.
   assign ev_i = oe_n ? 1'b1 : ev_o;

   swirq_top #(.N_INPUTS(4)) u_dut (
      .CLOCK(clock), .RST(rst), .SCLK(sclk), .CS_N(cs_n), .SI(si), .SO(so),
      .EVENT_N_I(ev_i), .EVENT_N_O(ev_o), .EVENT_N_OE_N(oe_n),
      .CHANGE_IRQ_ENABLE_A(en_a), .CHANGE_IRQ_ENABLE_B(en_b), .DEBOUNCE_SELECT(deb),
      .START_MONITOR(mon), .SAMPLE_STROBE(strb), .SAMPLE_ABOVE(above),
      .CURRENT_SINK_SEL(sink), .WETTING_SETTING(wset), .TEMP_WARN_IN(warn),
      .TEMP_SHUTDOWN_IN(shut), .WARN_KEEP_SOURCE_CURRENT(keep_so),
      .WARN_KEEP_SINK_CURRENT(keep_si), .WETTING_APPLIED(wapp), .REFERENCE_STATE(ref_st),
      .EVENT_STATUS(evs), .THERMAL_WARNING_LEVEL(wlev), .THERMAL_SHUTDOWN_LEVEL(slev),
      .POLL_RESTART(prst));

   swirq_host u_host (.SCLK(sclk), .CS_N(cs_n), .SI(si), .SO(so), .host_regulator_hold());

   // Compares one value and reports a mismatch at once.
   task automatic chk(input logic [32:0] got, input logic [32:0] exp);
      cmp_count++;
      if (got !== exp)
      begin
         errors++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk

   // Presents one detection result and waits for its outcome.
   task automatic strobe(input logic [3:0] s);
      @(posedge clock);
      strb <= 1'b1;
      above <= s;
      @(posedge clock);
      strb <= 1'b0;
      @(posedge clock);
      #1;
   endtask : strobe

   // Reads the event status word and checks the reply parity.
   task automatic rd(output logic [32:0] r);
      u_host.xfer({1'b0, 6'h21, 25'h0}, 1'b0, r);
      chk(^r, 1'b1);
      repeat (6) @(posedge clock);
      #1;
   endtask : rd

   // Lets the thermal synchronisers and current logic settle.
   task automatic settle;
      repeat (6) @(posedge clock);
      #1;
   endtask : settle

   task automatic final_report;
      $display("comparisons %0d mismatches %0d", cmp_count, errors);
      if (errors == 0 && cmp_count > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask : final_report

   initial
   begin
      repeat (3) @(posedge clock);
      rst <= 1'b0;
      settle();
      chk(oe_n, 1'b1);
      chk(evs, 4'h0);
      chk(wapp, 12'h4e5);
      @(posedge clock);
      mon <= 1'b1;
      strobe(4'h5);
      chk(ref_st, 4'h5);
      chk(oe_n, 1'b0);
      rd(rx);
      chk(rx[30], 1'b1);
      chk(rx[4:1], 4'h5);
      chk(evs, 4'h0);
      chk(oe_n, 1'b1);
      $display("first cycle test done");
      @(posedge clock);
      en_a <= 4'h5;
      en_b <= 4'h6;
      for (int i = 0; i < 6; i++)
      begin
         strobe(pat[i]);
         chk(ref_st, pat[i]);
         rd(rx);
         chk(rx[30], flg[i]);
      end
      $display("edge test done");
      @(posedge clock);
      deb <= 2'h3;
      repeat (3) strobe(4'hd);
      chk(ref_st, 4'h9);
      strobe(4'hd);
      chk(ref_st, 4'hd);
      chk(evs[0], 1'b1);
      rd(rx);
      @(posedge clock);
      mon <= 1'b0;
      strobe(4'h0);
      chk(ref_st, 4'hd);
      @(posedge clock);
      mon <= 1'b1;
      strobe(4'h0);
      chk(ref_st, 4'h0);
      chk(evs[0], 1'b1);
      rd(rx);
      $display("debounce test done");
      @(posedge clock);
      warn <= 1'b1;
      settle();
      chk({wlev, evs[1], oe_n}, 3'h6);
      chk(wapp, 12'h4d5);
      rd(rx);
      chk(rx[31], 1'b1);
      settle();
      chk({wlev, evs}, 5'h10);
      @(posedge clock);
      shut <= 1'b1;
      settle();
      chk({slev, wlev, evs[2], wapp}, 15'h7000);
      strobe(4'hf);
      chk(ref_st, 4'h0);
      rd(rx);
      @(posedge clock);
      shut <= 1'b0;
      settle();
      chk({slev, wlev, evs[2], wapp}, 15'h34d5);
      strobe(4'h3);
      chk(ref_st, 4'h3);
      chk(evs[0], 1'b1);
      rd(rx);
      @(posedge clock);
      warn <= 1'b0;
      settle();
      chk({wlev, evs[1], oe_n, wapp}, 15'h24e5);
      $display("thermal test done");
      u_host.xfer({1'b0, 6'h21, 25'h0}, 1'b1, rx);
      settle();
      chk({evs[3], evs[1], oe_n}, 3'h6);
      rd(rx);
      chk(rx[32], 1'b1);
      rd(rx);
      chk(rx[32:31], 2'h0);
      $display("parity test done");
      final_report();
   end

   initial
   begin
      #400000;
      errors++;
      final_report();
   end
endmodule : tb

`default_nettype wire
